// *** verilog/tc_channel.sv ***
module tc_channel
    import tc_pkg::*;
(
    input  wire logic                    clock,
    input  wire logic                    srst,
    input  wire logic                    ce,
    input  wire tc_pkg::channel_mode_reg_t mode,
    input  wire logic [4:0]              internal_prescaled_clock,
    input  wire logic [2:0]              ext_clk_in,
    input  wire logic                    io_line_a_in,
    input  wire logic                    io_line_b_in,
    input  wire logic [15:0]             compare_c_reg,
    input  wire logic                    clock_enable_cmd,
    input  wire logic                    clock_disable_cmd,
    input  wire logic                    software_trigger_cmd,
    input  wire logic                    sync_trigger,
    input  wire logic                    capture_b_load,
    input  wire logic                    overflow_clear,
    output logic [15:0]                  count_value_reg,
    output logic                         overflow_flag,
    output logic                         clock_enabled_status,
    output logic                         io_line_a_oe_n,
    output logic                         io_line_b_oe_n
);
    typedef struct packed {
        logic [15:0] count;
        logic        ovf;
        logic        enabled;
        logic        running;
        logic        trig_pending;
    } chan_state_t;

    chan_state_t state_ff;
    chan_state_t nxt_state;
    logic        sel_clk;
    logic        gate_ok;
    logic        ext_trig_src;
    logic        ext_trig;
    logic        trigger;
    logic        cmp_hit;
    logic        stop_evt;
    logic        dis_evt;
    logic        count_edge;

    edge_if clk_e ();
    edge_if trg_e ();

    always_comb
    begin
        if (mode.clock_select_field < clksel_first_ext)
            sel_clk = internal_prescaled_clock[mode.clock_select_field];
        else
            sel_clk = ext_clk_in[2'(mode.clock_select_field - clksel_first_ext)];
        unique case (mode.gate_select)
            gate_ext0: gate_ok = ext_clk_in[0];
            gate_ext1: gate_ok = ext_clk_in[1];
            gate_ext2: gate_ok = ext_clk_in[2];
            gate_none: gate_ok = 1'b1;
        endcase
        if (!mode.wave_mode)
            ext_trig_src = mode.capture_trig_from_b ? io_line_b_in : io_line_a_in;
        else if (mode.ext_event_select == eevt_line_b)
            ext_trig_src = io_line_b_in;
        else
            ext_trig_src = ext_clk_in[2'(mode.ext_event_select - 2'h1)];
    end

    assign clk_e.level = sel_clk ^ mode.clock_invert_bit;
    assign trg_e.level = ext_trig_src;

    edge_detect u_clk_edge (.clock(clock), .srst(srst), .ce(ce), .sig(clk_e));
    edge_detect u_trg_edge (.clock(clock), .srst(srst), .ce(ce), .sig(trg_e));

    always_comb
    begin
        unique case (mode.ext_trig_edge)
            edge_rising:  ext_trig = trg_e.rise;
            edge_falling: ext_trig = trg_e.fall;
            edge_both:    ext_trig = trg_e.rise | trg_e.fall;
            edge_none:    ext_trig = 1'b0;
        endcase
        // waveform mode only triggers externally when enabled
        if (mode.wave_mode && !mode.ext_event_trigger_enable)
            ext_trig = 1'b0;
    end

    assign count_edge = clk_e.rise & gate_ok;
    assign cmp_hit    = ce & (state_ff.count == compare_c_reg);
    assign trigger    = ce & (software_trigger_cmd | sync_trigger
                        | (cmp_hit & mode.c_compare_trigger_enable)
                        | ext_trig);
    assign stop_evt   = mode.wave_mode ? cmp_hit & mode.stop_on_c_compare
                                       : capture_b_load & mode.stop_on_b_load;
    assign dis_evt    = mode.wave_mode ? cmp_hit & mode.disable_on_c_compare
                                       : capture_b_load & mode.disable_on_b_load;

    always_comb
    begin
        nxt_state = state_ff;
        if (trigger)
            nxt_state.trig_pending = 1'b1;
        if (state_ff.enabled)
        begin
            if (stop_evt)
                nxt_state.running = 1'b0;
            if (trigger)
                nxt_state.running = 1'b1;
        end
        if (ce && dis_evt)
            nxt_state.enabled = 1'b0;
        if (ce && clock_disable_cmd)
            nxt_state.enabled = 1'b0;
        else if (ce && clock_enable_cmd)
            nxt_state.enabled = 1'b1;
        if (!nxt_state.enabled)
            nxt_state.running = 1'b0;
        if (count_edge && state_ff.enabled && (state_ff.running || state_ff.trig_pending))
        begin
            if (state_ff.trig_pending)
            begin
                nxt_state.count        = count_reset_val;
                nxt_state.trig_pending = trigger;
            end
            else
            begin
                nxt_state.count = state_ff.count + 16'h0001;
                if (state_ff.count == count_max_val)
                    nxt_state.ovf = 1'b1;
            end
        end
        // an overflow that sets the flag wins over a clear in the same cycle
        if (ce && overflow_clear && !(nxt_state.ovf && !state_ff.ovf))
            nxt_state.ovf = 1'b0;
    end

    always_ff @(posedge clock)
    begin
        if (srst)
            state_ff <= '0;
        else if (ce)
            state_ff <= nxt_state;
    end

    assign count_value_reg      = state_ff.count;
    assign overflow_flag        = state_ff.ovf;
    assign clock_enabled_status = state_ff.enabled;
    // output enable low means driving
    assign io_line_a_oe_n = ~mode.wave_mode;
    assign io_line_b_oe_n = ~mode.wave_mode
                            | (mode.ext_event_select == eevt_line_b
                               && mode.ext_trig_edge != edge_none);

    a_ovf_on_wrap: assert property (@(posedge clock) disable iff (srst)
        (ce && count_edge && state_ff.enabled && state_ff.running && !state_ff.trig_pending
         && state_ff.count == count_max_val) |=> overflow_flag && count_value_reg == 16'h0000)
        else $error("overflow not flagged on wrap");
    a_status_enabled: assert property (@(posedge clock) disable iff (srst)
        (ce && clock_disable_cmd) |=> !clock_enabled_status)
        else $error("disable command ignored");
    a_count_hold_dis: assert property (@(posedge clock) disable iff (srst)
        !clock_enabled_status |=> $stable(count_value_reg) || !$past(ce) || clock_enabled_status)
        else $error("count moved while disabled");
endmodule

// *** inc/tc_pkg.sv ***
package tc_pkg;
    localparam int num_channels = 3;
    localparam int count_width  = 16;
    localparam logic [15:0] count_reset_val = 16'h0000;
    localparam logic [15:0] count_max_val   = 16'hFFFF;
    localparam logic [2:0]  clksel_reset    = 3'h0;
    // clock select codes: 0..4 internal prescaled, 5..7 ext_clk_in0..2
    localparam logic [2:0]  clksel_first_ext = 3'h5;
    // gate select codes
    localparam logic [1:0]  gate_none = 2'h0;
    localparam logic [1:0]  gate_ext0 = 2'h1;
    localparam logic [1:0]  gate_ext1 = 2'h2;
    localparam logic [1:0]  gate_ext2 = 2'h3;
    // external trigger edge codes
    localparam logic [1:0]  edge_none    = 2'h0;
    localparam logic [1:0]  edge_rising  = 2'h1;
    localparam logic [1:0]  edge_falling = 2'h2;
    localparam logic [1:0]  edge_both    = 2'h3;
    // waveform external event source codes
    localparam logic [1:0]  eevt_line_b = 2'h0;
    // clock sample pipeline depth, not used by edge_detect, which keeps a single previous sample
    localparam int sample_depth = 2;

    typedef struct packed {
        logic [2:0] clock_select_field;
        logic       clock_invert_bit;
        logic [1:0] gate_select;
        logic       wave_mode;
        logic       disable_on_b_load;
        logic       stop_on_b_load;
        logic       disable_on_c_compare;
        logic       stop_on_c_compare;
        logic       c_compare_trigger_enable;
        logic       ext_event_trigger_enable;
        logic       capture_trig_from_b;
        logic [1:0] ext_trig_edge;
        logic [1:0] ext_event_select;
    } channel_mode_reg_t;
endpackage

// *** inc/edge_if.sv ***
interface edge_if;
    logic level;
    logic rise;
    logic fall;
    modport det  (input level, output rise, output fall);
    modport user (output level, input rise, input fall);
endinterface

// *** verilog/edge_detect.sv ***
module edge_detect
    import tc_pkg::*;
(
    input  wire logic clock,
    input  wire logic srst,
    input  wire logic ce,
    edge_if.det       sig
);
    typedef struct packed {
        logic prev;
    } edge_state_t;

    edge_state_t state_ff;
    edge_state_t nxt_state;

    always_comb
    begin
        nxt_state      = state_ff;
        nxt_state.prev = sig.level;
    end

    always_ff @(posedge clock)
    begin
        // reset loads the live level, so an input resting high shows no false edge
        if (srst || ce)
            state_ff <= nxt_state;
    end

    // edges are pulses gated with ce so a frozen block sees no events
    assign sig.rise = ce & sig.level & ~state_ff.prev;
    assign sig.fall = ce & ~sig.level & state_ff.prev;
endmodule

// *** verilog/tc_block.sv ***
module tc_block
    import tc_pkg::*;
#(
    parameter int channels = 3
)
(
    input  wire logic                                clock,
    input  wire logic                                srst,
    input  wire logic                                ce,
    input  wire logic                                debug_halt,
    input  wire logic                                debug_keep_running,
    input  wire tc_pkg::channel_mode_reg_t [2:0]     channel_mode_reg,
    input  wire logic [5:0]                          block_mode_reg,
    input  wire logic [4:0]                          internal_prescaled_clock,
    input  wire logic [2:0]                          ext_clock_pin,
    input  wire logic [2:0]                          io_line_a_in,
    input  wire logic [2:0]                          io_line_b_in,
    input  wire logic [2:0][15:0]                    compare_c_reg,
    input  wire logic [2:0]                          clock_enable_cmd,
    input  wire logic [2:0]                          clock_disable_cmd,
    input  wire logic [2:0]                          software_trigger_cmd,
    input  wire logic                                block_sync_cmd,
    input  wire logic [2:0]                          capture_b_load,
    input  wire logic [2:0]                          overflow_clear,
    output logic [2:0][15:0]                         count_value_reg,
    output logic [2:0]                               overflow_flag,
    output logic [2:0]                               clock_enabled_status,
    output logic [2:0]                               io_line_a_oe_n,
    output logic [2:0]                               io_line_b_oe_n
);
    logic       run_ce;
    logic [2:0] ext_clk_in;

    if (channels != num_channels)
        $error("tc_block supports exactly three channels");

    // freezing via the enable keeps every channel consistent in debug
    assign run_ce = ce & (~debug_halt | debug_keep_running);

    // per ext clock input: 0 pin, 1 io line a of a neighbour channel
    always_comb
    begin
        ext_clk_in[0] = block_mode_reg[1:0] == 2'h0 ? ext_clock_pin[0]
                      : block_mode_reg[1:0] == 2'h1 ? io_line_a_in[1] : io_line_a_in[2];
        ext_clk_in[1] = block_mode_reg[3:2] == 2'h0 ? ext_clock_pin[1]
                      : block_mode_reg[3:2] == 2'h1 ? io_line_a_in[0] : io_line_a_in[2];
        ext_clk_in[2] = block_mode_reg[5:4] == 2'h0 ? ext_clock_pin[2]
                      : block_mode_reg[5:4] == 2'h1 ? io_line_a_in[0] : io_line_a_in[1];
    end

    for (genvar i = 0; i < 3; i++)
    begin : g_ch
        tc_channel u_ch (
            .clock                    (clock),
            .srst                     (srst),
            .ce                       (run_ce),
            .mode                     (channel_mode_reg[i]),
            .internal_prescaled_clock (internal_prescaled_clock),
            .ext_clk_in               (ext_clk_in),
            .io_line_a_in             (io_line_a_in[i]),
            .io_line_b_in             (io_line_b_in[i]),
            .compare_c_reg            (compare_c_reg[i]),
            .clock_enable_cmd         (clock_enable_cmd[i]),
            .clock_disable_cmd        (clock_disable_cmd[i]),
            .software_trigger_cmd     (software_trigger_cmd[i]),
            .sync_trigger             (block_sync_cmd),
            .capture_b_load           (capture_b_load[i]),
            .overflow_clear           (overflow_clear[i]),
            .count_value_reg          (count_value_reg[i]),
            .overflow_flag            (overflow_flag[i]),
            .clock_enabled_status     (clock_enabled_status[i]),
            .io_line_a_oe_n           (io_line_a_oe_n[i]),
            .io_line_b_oe_n           (io_line_b_oe_n[i])
        );
    end

    a_sync_all: assert property (@(posedge clock) disable iff (srst)
        (run_ce && block_sync_cmd && &clock_enabled_status && !(|clock_disable_cmd))
        |=> &clock_enabled_status)
        else $error("sync lost enable");
    a_debug_freeze: assert property (@(posedge clock) disable iff (srst)
        (debug_halt && !debug_keep_running) |=> $stable(count_value_reg))
        else $error("counter moved in debug halt");
    a_dir_capture: assert property (@(posedge clock) disable iff (srst)
        !channel_mode_reg[0].wave_mode |-> io_line_a_oe_n[0] && io_line_b_oe_n[0])
        else $error("capture mode drives lines");
endmodule

// *** test/clock_source_model.sv ***
module clock_source_model (
    input  wire logic       clock,
    input  wire logic       ext_run,
    input  wire logic [2:0] pulse_b,
    output logic      [4:0] internal_prescaled_clock,
    output logic      [2:0] ext_clock_pin,
    output logic      [2:0] io_line_b_in
);
    timeunit 1ns;
    timeprecision 1ns;
    int cyc = 0;
    int hold [3] = '{0, 0, 0};
    // half periods of 2..6 cycles keep every level longer than one bus cycle
    always @(posedge clock)
    begin
        cyc <= cyc + 1;
        for (int k = 0; k < 5; k++)
            internal_prescaled_clock[k] <= 1'((cyc / (k + 2)) % 2);
        for (int k = 0; k < 3; k++)
        begin
            // pins rest low between runs, as with a pull-down
            ext_clock_pin[k] <= ext_run && 1'((cyc / 3) % 2);
            hold[k] <= pulse_b[k] ? 3 : (hold[k] > 0 ? hold[k] - 1 : 0);
            io_line_b_in[k] <= pulse_b[k] || hold[k] > 1;
        end
    end
endmodule

// *** test/timer_counter_channel_core_test.sv ***
module timer_counter_channel_core_test;
    timeunit 1ns;
    timeprecision 1ns;
    import tc_pkg::*;
    logic                    clock = 1'b0;
    logic                    srst = 1'b1;
    logic                    ce = 1'b1;
    logic                    dbg_halt = 1'b0;
    logic                    dbg_run = 1'b0;
    channel_mode_reg_t [2:0] mode = '0;
    logic [5:0]              bmode = 6'h00;
    logic [2:0][15:0]        cmp_c = '0;
    logic [2:0]              en_cmd = 3'h0;
    logic [2:0]              dis_cmd = 3'h0;
    logic [2:0]              sw_trig = 3'h0;
    logic                    sync_cmd = 1'b0;
    logic                    ext_run = 1'b0;
    logic [2:0]              pulse_b = 3'h0;
    logic [2:0]              b_load = 3'h0;
    logic [4:0]              int_clk;
    logic [2:0]              ext_pin;
    logic [2:0]              line_b;
    logic [2:0][15:0]        cnt;
    logic [2:0]              ovf;
    logic [2:0]              sta;
    logic [2:0]              a_oe_n;
    logic [2:0]              b_oe_n;
    logic [15:0]             held;
    int                      bad_count = 0;
    int                      n_compared = 0;
    int                      cycles = 0;

    always #20 clock = ~clock;

    clock_source_model i_clock_source_model (.clock(clock), .ext_run(ext_run),
        .pulse_b(pulse_b), .internal_prescaled_clock(int_clk), .ext_clock_pin(ext_pin),
        .io_line_b_in(line_b));

    tc_block i_tc_block (.clock(clock), .srst(srst), .ce(ce), .debug_halt(dbg_halt),
        .debug_keep_running(dbg_run), .channel_mode_reg(mode), .block_mode_reg(bmode),
        .internal_prescaled_clock(int_clk), .ext_clock_pin(ext_pin),
        .io_line_a_in(3'h0), .io_line_b_in(line_b), .compare_c_reg(cmp_c),
        .clock_enable_cmd(en_cmd), .clock_disable_cmd(dis_cmd),
        .software_trigger_cmd(sw_trig), .block_sync_cmd(sync_cmd),
        .capture_b_load(b_load), .overflow_clear(3'h0), .count_value_reg(cnt),
        .overflow_flag(ovf), .clock_enabled_status(sta), .io_line_a_oe_n(a_oe_n),
        .io_line_b_oe_n(b_oe_n));

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clock);
    endtask

    // kinds: 0 enable, 1 disable, 2 software trigger, 3 sync, 4 pulse on line b, 5 b load
    task automatic pulse(input int kind, input int ch);
        @(posedge clock);
        case (kind)
            0: en_cmd[ch] <= 1'b1;
            1: dis_cmd[ch] <= 1'b1;
            2: sw_trig[ch] <= 1'b1;
            3: sync_cmd <= 1'b1;
            5: b_load[ch] <= 1'b1;
            default: pulse_b[ch] <= 1'b1;
        endcase
        @(posedge clock);
        en_cmd <= 3'h0;
        dis_cmd <= 3'h0;
        sw_trig <= 3'h0;
        sync_cmd <= 1'b0;
        pulse_b <= 3'h0;
        b_load <= 3'h0;
    endtask

    task automatic in_range(input int ch, input int lo, input int hi);
        #1;
        check(16'(cnt[ch] >= lo && cnt[ch] <= hi), 16'h0001);
    endtask

    // count unchanged across n cycles
    task automatic frozen(input int ch, input int n);
        #1;
        held = cnt[ch];
        tick(n);
        #1;
        check(cnt[ch], held);
    endtask

    task automatic give_verdict();
        $display("compared %0d, mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // the whole sequence needs under 2000 cycles
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            bad_count++;
            give_verdict();
        end
    end

    initial
    begin
        tick(16);
        srst <= 1'b0;
        tick(1);
        #1;
        for (int c = 0; c < 3; c++)
        begin
            check(cnt[c], 16'h0000);
            check(16'(ovf[c]), 16'h0000);
            check(16'(sta[c]), 16'h0000);
            check(16'({a_oe_n[c], b_oe_n[c]}), 16'h0003);
        end
        $display("test reset done");
        for (int c = 0; c < 3; c++)
        begin
            pulse(0, c);
            #1;
            check(16'(sta[c]), 16'h0001);
            pulse(2, c);
        end
        tick(40);
        for (int c = 0; c < 3; c++)
            in_range(c, 8 - c, 13 - c);
        for (int k = 0; k < 5; k++)
        begin
            @(posedge clock);
            mode[0].clock_select_field <= 3'(k);
            pulse(2, 0);
            tick(60);
            in_range(0, 60 / (2 * k + 4) - 2, 60 / (2 * k + 4) + 1);
        end
        @(posedge clock);
        mode[0].clock_select_field <= 3'h0;
        $display("test counting done");
        pulse(1, 0);
        #1;
        check(16'(sta[0]), 16'h0000);
        frozen(0, 20);
        pulse(2, 0);
        frozen(0, 20);
        pulse(0, 0);
        pulse(2, 0);
        tick(10);
        in_range(0, 0, 3);
        tick(60);
        pulse(3, 0);
        tick(10);
        for (int c = 0; c < 3; c++)
            in_range(c, 0, 3);
        $display("test enable and triggers done");
        @(posedge clock);
        cmp_c[1] <= 16'h0006;
        mode[1].c_compare_trigger_enable <= 1'b1;
        tick(200);
        in_range(1, 0, 6);
        @(posedge clock);
        mode[1].c_compare_trigger_enable <= 1'b0;
        for (int c = 0; c < 3; c++)
        begin
            @(posedge clock);
            mode[c].wave_mode <= 1'b1;
            mode[c].ext_event_select <= eevt_line_b;
            // line b is an event input only once an edge is chosen for it
            mode[c].ext_trig_edge <= edge_rising;
            tick(1);
            #1;
            check(16'({a_oe_n[c], b_oe_n[c]}), 16'h0001);
            @(posedge clock);
            mode[c].ext_event_select <= 2'h1;
            tick(1);
            #1;
            check(16'({a_oe_n[c], b_oe_n[c]}), 16'h0000);
            @(posedge clock);
            mode[c].wave_mode <= 1'b0;
            mode[c].ext_event_select <= eevt_line_b;
            mode[c].ext_trig_edge <= edge_none;
        end
        $display("test compare and modes done");
        @(posedge clock);
        mode[1].stop_on_b_load <= 1'b1;
        pulse(5, 1);
        frozen(1, 20);
        check(16'(sta[1]), 16'h0001);
        @(posedge clock);
        mode[1].disable_on_b_load <= 1'b1;
        pulse(5, 1);
        #1;
        check(16'(sta[1]), 16'h0000);
        @(posedge clock);
        mode[1].stop_on_b_load <= 1'b0;
        mode[1].disable_on_b_load <= 1'b0;
        mode[1].wave_mode <= 1'b1;
        mode[1].stop_on_c_compare <= 1'b1;
        cmp_c[1] <= 16'h0005;
        pulse(0, 1);
        pulse(2, 1);
        tick(60);
        #1;
        check(cnt[1], 16'h0005);
        check(16'(sta[1]), 16'h0001);
        @(posedge clock);
        mode[1].disable_on_c_compare <= 1'b1;
        tick(2);
        #1;
        check(16'(sta[1]), 16'h0000);
        $display("test stop and disable done");
        @(posedge clock);
        ext_run <= 1'b1;
        mode[2].clock_select_field <= clksel_first_ext;
        pulse(2, 2);
        tick(60);
        in_range(2, 7, 11);
        // gate from input 1 rerouted to line a of channel 0, which rests low
        @(posedge clock);
        mode[2].gate_select <= gate_ext1;
        bmode <= 6'h04;
        tick(4);
        frozen(2, 30);
        @(posedge clock);
        dbg_halt <= 1'b1;
        tick(2);
        frozen(0, 20);
        @(posedge clock);
        dbg_run <= 1'b1;
        tick(20);
        #1;
        check(16'(cnt[0] != held), 16'h0001);
        $display("test clocks and debug done");
        @(posedge clock);
        dbg_halt <= 1'b0;
        dbg_run <= 1'b0;
        mode[0].capture_trig_from_b <= 1'b1;
        mode[0].ext_trig_edge <= edge_rising;
        tick(40);
        in_range(0, 8, 16'hFFFF);
        pulse(4, 0);
        tick(12);
        in_range(0, 0, 3);
        $display("test external trigger done");
        give_verdict();
    end
endmodule
